/* File: pkg/acp_map.vh */
// Constants for the converter control and result output port
`ifndef ACP_MAP_VH
`define ACP_MAP_VH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define ACP_CLK_MHZ         100
`define ACP_T_CONV_NS       250
`define ACP_T_ACQ_NS        80
`define ACP_T_SCLK_PHASE_NS 20
// Least times, rounded up to whole cycles
`define ACP_CONV_CYC  ((`ACP_T_CONV_NS * `ACP_CLK_MHZ + 999) / 1000)
`define ACP_ACQ_CYC   ((`ACP_T_ACQ_NS * `ACP_CLK_MHZ + 999) / 1000)
`define ACP_PHASE_CYC ((`ACP_T_SCLK_PHASE_NS * `ACP_CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------
// Widths and counts
// ------------------------------------------------------------
`define ACP_RES_W     16
`define ACP_BITS      5'd16
`define ACP_LAST_BIT  5'd15
`define ACP_EXT_CAP   5'd17
`define ACP_CNT_W     8
`define ACP_SYNC_W    16
`define ACP_SYNC_N_W  3

// ------------------------------------------------------------
// Shared pin positions in serial mode
// ------------------------------------------------------------
`define ACP_PIN_SDO   8
`define ACP_PIN_SCLK  9
`define ACP_PIN_SYNC  10
`define ACP_PIN_ERR   11
`define ACP_PIN_MSB   15
`define ACP_PIN_HI_LO 12

// ------------------------------------------------------------
// Conversion states, one-hot
// ------------------------------------------------------------
`define ACP_ST_IDLE 3'h1
`define ACP_ST_CONV 3'h2
`define ACP_ST_ACQ  3'h4

// ------------------------------------------------------------
// Serial clock phases
// ------------------------------------------------------------
`define ACP_PH_DATA 2'h0
`define ACP_PH_RISE 2'h1
`define ACP_PH_FALL 2'h3

`endif

/* File: rtl/acp_sync.v */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none

module acp_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q   <= {W{INIT}};
      sync_out <= {W{INIT}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // acp_sync

`default_nettype wire

/* File: rtl/acp_top.v */
// Conversion control and parallel/serial result port
// Summary of operation
// - Parallel mode: shared pins carry result bits, pin 8 carries bit 8.
// - Result bits 12 to 15 are outputs in every mode.
// - Serial mode shifts the stored result out MSB first.
// - Output number format follows the format select level.
// - Internal clock: serial data stable across both clock edges.
// - External clock, no invert: data changes on rise, valid at fall.
// - External clock, invert: data changes on fall, valid at rise.
// - Serial clock pin is output or input per clock source select.
// - Internal mode, polarity low: marker high while serial data valid.
// - Internal mode, polarity high: marker low while serial data valid.
// - External mode: unfinished read at conversion end drops data, pulses error.
// - Busy high from conversion start until result is latched.
// - Output drivers on only while chip select and read both low.
// - Chip select gates the external serial clock.
// - Reset pin high resets and aborts any conversion.
// - Power-down lets the current conversion finish, then blocks new ones.
// - Falling convert strobe enters hold and starts a conversion.
// - Low-power mode with fast mode low: strobe low at acquisition end starts conversion at once.
// - Clock source low drives internal clock; high follows external clock.
// - Internal mode: read-mode high reads during conversion, low after it.
// - External mode: chain input appears 16 clock periods after read start.
`timescale 1ns/100ps
`default_nettype none
`include "acp_map.vh"

module acp_top (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        reset_pin,
  input  wire        power_down_input,
  input  wire        convert_strobe_n,
  input  wire        low_power_select,
  input  wire        fast_mode_select,
  input  wire        serial_parallel_select,
  input  wire        clock_source_select,
  input  wire        clock_invert_select,
  input  wire        marker_polarity_select,
  input  wire        output_format_select,
  input  wire        readmode_or_chain_input,
  input  wire [1:0]  clock_divide_select,
  input  wire        cs_n,
  input  wire        rd_n,
  input  wire        sclk_i,
  input  wire [15:0] adc_code,
  output reg  [15:0] data_o,
  output reg  [15:0] data_oe,
  output reg         busy,
  output reg         sample_hold,
  output reg         power_save
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire [`ACP_SYNC_W-`ACP_SYNC_N_W-1:0] pins_s;
  wire [`ACP_SYNC_N_W-1:0]             pins_n_s;
  wire        strobe_n_s;
  wire        rst_pin_s;
  wire        pd_s;
  wire        sclk_s;
  wire        cs_n_s;
  wire        rd_n_s;
  wire        chain_s;
  wire        ser_s;
  wire        ext_s;
  wire        inv_s;
  wire        marker_polarity_select_s;
  wire        fmt_s;
  wire [1:0]  div_s;
  wire        lp_s;
  wire        fast_s;

  acp_sync #(
    .W    (`ACP_SYNC_W-`ACP_SYNC_N_W),
    .INIT (1'b0)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({reset_pin, power_down_input, sclk_i, readmode_or_chain_input,
                serial_parallel_select, clock_source_select, clock_invert_select,
                marker_polarity_select, output_format_select, clock_divide_select,
                low_power_select, fast_mode_select}),
    .sync_out (pins_s)
  );

  // Active-low pins reset to idle high: no false strobe edge, no drivers on
  acp_sync #(
    .W    (`ACP_SYNC_N_W),
    .INIT (1'b1)
  ) u_sync_n (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({convert_strobe_n, cs_n, rd_n}),
    .sync_out (pins_n_s)
  );

  assign {rst_pin_s, pd_s, sclk_s, chain_s, ser_s, ext_s, inv_s, marker_polarity_select_s, fmt_s,
          div_s, lp_s, fast_s} = pins_s;
  assign {strobe_n_s, cs_n_s, rd_n_s} = pins_n_s;

  wire rst = !resetn || rst_pin_s;

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  reg  [2:0]            state_q;
  reg  [`ACP_CNT_W-1:0] tcnt_q;
  reg                   strobe_prev_q;
  reg  [15:0]           result_q;
  reg                   conv_done_q;
  reg                   conv_start_q;

  wire strobe_fall = strobe_prev_q && !strobe_n_s;
  wire impulse     = lp_s && !fast_s;

  always @(posedge clk_sys) begin
    if (rst) begin
      state_q       <= `ACP_ST_IDLE;
      tcnt_q        <= {`ACP_CNT_W{1'b0}};
      strobe_prev_q <= 1'b1;
      result_q      <= 16'h0000;
      conv_done_q   <= 1'b0;
      conv_start_q  <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_n_s;
      conv_done_q   <= 1'b0;
      conv_start_q  <= 1'b0;
      case (state_q)
        `ACP_ST_IDLE: begin
          // Power-down only blocks new starts
          if (strobe_fall && !pd_s) begin
            state_q      <= `ACP_ST_CONV;
            tcnt_q       <= {`ACP_CNT_W{1'b0}};
            conv_start_q <= 1'b1;
          end
        end
        `ACP_ST_CONV: begin
          if (tcnt_q == `ACP_CONV_CYC - 1) begin
            state_q     <= `ACP_ST_ACQ;
            tcnt_q      <= {`ACP_CNT_W{1'b0}};
            conv_done_q <= 1'b1;
            // Core code is offset binary; MSB flip gives two's complement
            result_q    <= fmt_s ? adc_code
                                 : {~adc_code[15], adc_code[14:0]};
          end else begin
            tcnt_q <= tcnt_q + 1'b1;
          end
        end
        `ACP_ST_ACQ: begin
          if (tcnt_q == `ACP_ACQ_CYC - 1) begin
            tcnt_q <= {`ACP_CNT_W{1'b0}};
            if (impulse && !strobe_n_s && !pd_s) begin
              state_q      <= `ACP_ST_CONV;
              conv_start_q <= 1'b1;
            end else begin
              state_q <= `ACP_ST_IDLE;
            end
          end else begin
            tcnt_q <= tcnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= `ACP_ST_IDLE;
          tcnt_q  <= {`ACP_CNT_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      busy        <= 1'b0;
      sample_hold <= 1'b0;
      power_save  <= 1'b0;
    end else begin
      busy        <= (state_q == `ACP_ST_CONV) && !conv_done_q
                     || conv_start_q;
      sample_hold <= (state_q == `ACP_ST_CONV);
      power_save  <= pd_s && (state_q != `ACP_ST_CONV);
    end
  end

  // ------------------------------------------------------------
  // Internal-clock serial engine
  // ------------------------------------------------------------
  reg                   ms_run_q;
  reg  [1:0]            ms_phase_q;
  reg  [`ACP_CNT_W-1:0] ms_cnt_q;
  reg  [4:0]            ms_bit_q;
  reg                   sclk_int_q;

  wire int_mode = ser_s && !ext_s;
  // Divider only applies to read-after-convert
  wire [1:0] div_eff = chain_s ? 2'h0 : div_s;
  wire [31:0]           ph_full = `ACP_PHASE_CYC << div_eff;
  wire [`ACP_CNT_W-1:0] ph_len  = ph_full[`ACP_CNT_W-1:0];
  wire ms_tick  = ms_run_q && (ms_cnt_q == ph_len - 1'b1);
  wire ms_start = int_mode && !ms_run_q &&
                  (chain_s ? conv_start_q : conv_done_q);
  wire ms_shift = ms_tick && (ms_phase_q == `ACP_PH_FALL)
                  && (ms_bit_q != `ACP_LAST_BIT);

  always @(posedge clk_sys) begin
    if (rst || !int_mode) begin
      ms_run_q   <= 1'b0;
      ms_phase_q <= `ACP_PH_DATA;
      ms_cnt_q   <= {`ACP_CNT_W{1'b0}};
      ms_bit_q   <= 5'd0;
      sclk_int_q <= 1'b0;
    end else if (ms_start) begin
      ms_run_q   <= 1'b1;
      ms_phase_q <= `ACP_PH_DATA;
      ms_cnt_q   <= {`ACP_CNT_W{1'b0}};
      ms_bit_q   <= 5'd0;
    end else if (ms_tick) begin
      ms_cnt_q   <= {`ACP_CNT_W{1'b0}};
      ms_phase_q <= ms_phase_q + 1'b1;
      // Data moves mid-low, so both edges see it stable
      if (ms_phase_q == `ACP_PH_DATA) begin
        sclk_int_q <= 1'b1;
      end
      if (ms_phase_q == `ACP_PH_RISE + 2'h1) begin
        sclk_int_q <= 1'b0;
      end
      if (ms_phase_q == `ACP_PH_FALL) begin
        if (ms_bit_q == `ACP_LAST_BIT) begin
          ms_run_q <= 1'b0;
        end
        ms_bit_q <= ms_bit_q + 1'b1;
      end
    end else if (ms_run_q) begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // External-clock serial engine
  // ------------------------------------------------------------
  reg        es_prev_q;
  reg  [4:0] es_cnt_q;
  reg        err_q;

  wire ext_mode = ser_s && ext_s;
  wire es_rise  = sclk_s && !es_prev_q;
  wire es_fall  = !sclk_s && es_prev_q;
  // Clock edges count only while selected
  wire es_upd   = ext_mode && !cs_n_s &&
                  (inv_s ? es_fall : es_rise);
  wire es_shift = es_upd && (es_cnt_q != 5'd0);
  wire es_part  = (es_cnt_q != 5'd0) && (es_cnt_q < `ACP_BITS);

  always @(posedge clk_sys) begin
    if (rst) begin
      es_prev_q <= 1'b0;
      es_cnt_q  <= 5'd0;
      err_q     <= 1'b0;
    end else begin
      es_prev_q <= sclk_s;
      err_q     <= conv_done_q && ext_mode && es_part;
      if (conv_done_q) begin
        es_cnt_q <= 5'd0;
      end else if (es_upd && es_cnt_q != `ACP_EXT_CAP) begin
        es_cnt_q <= es_cnt_q + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Output shift register
  // ------------------------------------------------------------
  reg [15:0] shreg_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      shreg_q <= 16'h0000;
    end else if (ext_mode && conv_done_q) begin
      // New result replaces any unfinished read
      shreg_q <= fmt_s ? adc_code
                       : {~adc_code[15], adc_code[14:0]};
    end else if (ms_start) begin
      shreg_q <= chain_s ? result_q
                 : (fmt_s ? adc_code : {~adc_code[15], adc_code[14:0]});
    end else if (ms_shift) begin
      shreg_q <= {shreg_q[14:0], 1'b0};
    end else if (es_shift) begin
      shreg_q <= {shreg_q[14:0], chain_s};
    end
  end

  // ------------------------------------------------------------
  // Pin multiplexing and drivers
  // ------------------------------------------------------------
  reg  [15:0] pin_d;
  reg  [15:0] oe_d;
  wire        drv_en = !cs_n_s && !rd_n_s;

  always @* begin
    pin_d = result_q;
    oe_d  = {16{drv_en}};
    if (ser_s) begin
      pin_d[`ACP_PIN_SDO]  = shreg_q[15];
      pin_d[`ACP_PIN_SCLK] = sclk_int_q ^ inv_s;
      pin_d[`ACP_PIN_SYNC] = ms_run_q ^ marker_polarity_select_s;
      pin_d[`ACP_PIN_ERR]  = err_q;
      oe_d[`ACP_PIN_SDO-1:0] = 8'h00;
      oe_d[`ACP_PIN_SCLK]  = drv_en && !ext_s;
      oe_d[`ACP_PIN_SYNC]  = drv_en && !ext_s;
      oe_d[`ACP_PIN_ERR]   = drv_en && ext_s;
      oe_d[`ACP_PIN_SDO-1] = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      data_o  <= 16'h0000;
      data_oe <= 16'h0000;
    end else begin
      data_o  <= pin_d;
      data_oe <= oe_d;
    end
  end

endmodule // acp_top

`default_nettype wire

/* File: test/acp_monitor.sv */
// Assertion checker on the ports of the converter control block
`timescale 1ns/100ps
`default_nettype none
module acp_monitor (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        reset_pin,
  input wire logic        cs_n,
  input wire logic        serial_parallel_select,
  input wire logic        clock_source_select,
  input wire logic [15:0] data_o,
  input wire logic [15:0] data_oe,
  input wire logic        busy,
  input wire logic        sample_hold,
  input wire logic        power_save
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn || reset_pin);
  // ----------------------------------------
  // Port rules
  // ----------------------------------------
  oe_gate_a: assert property (cs_n [*5] |=> data_oe == 16'h0000)
    else $error("drivers on while deselected");
  hi_bits_a: assert property (data_oe != 16'h0000 |-> data_oe[15:12] == 4'hF)
    else $error("upper result bits not driven");
  par_oe_a: assert property (!serial_parallel_select
    && !$past(serial_parallel_select, 5) && data_oe != 16'h0000 |-> data_oe == 16'hFFFF)
    else $error("parallel bus partly driven");
  busy_len_a: assert property ($rose(busy)
    |-> busy [*8] ##1 busy [*8] ##1 busy [*8] ##1 busy ##1 !busy)
    else $error("busy length wrong");
  hold_a: assert property ($rose(busy) |-> sample_hold)
    else $error("no hold at conversion start");
  acq_gap_a: assert property ($fell(busy) |-> !busy [*8])
    else $error("restart inside acquisition");
  pd_block_a: assert property (power_save && $past(power_save) |-> !$rose(busy))
    else $error("conversion in power-down");
  err_one_a: assert property (serial_parallel_select
    && clock_source_select && $rose(data_o[11]) |=> !data_o[11])
    else $error("error flag longer than a pulse");
  ext_oe_a: assert property ((serial_parallel_select && clock_source_select) [*5]
    |=> data_oe[10:9] == 2'b00 && data_oe[7:0] == 8'h00)
    else $error("marker or clock driven in host clock mode");
  rst_out_a: assert property (disable iff (1'b0) !resetn |=> !busy && data_oe == 16'h0000)
    else $error("outputs live in reset");
endmodule // acp_monitor
bind acp_top acp_monitor acp_monitor_i (.clk_sys, .resetn, .reset_pin, .cs_n,
  .serial_parallel_select, .clock_source_select, .data_o, .data_oe, .busy,
  .sample_hold, .power_save);
`default_nettype wire

/* File: test/acp_host.sv */
// Host model reading results over the serial port on its own clock
`timescale 1ns/100ps
`default_nettype none
module acp_host (
  output logic      sclk_i,
  output logic      cs_n,
  output logic      rd_n,
  input  wire logic sdo
);
  initial begin
    sclk_i = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  task automatic sel(input logic v);
    cs_n = v;
    rd_n = v;
  endtask
  // Clock runs two periods while still deselected before each frame; idle level follows the inversion
  task automatic frame(input int n, input logic inv, output logic [17:0] got);
    sclk_i = inv;
    #80;
    repeat (4) begin
      sclk_i = ~sclk_i;
      #80;
    end
    sel(1'b0);
    #160;
    got = 18'h00000;
    for (int i = 0; i < n; i++) begin
      sclk_i = ~inv;
      #80;
      got = {got[16:0], sdo};
      sclk_i = inv;
      #80;
    end
    sel(1'b1);
  endtask
endmodule // acp_host
`default_nettype wire

/* File: test/acp_top_bench.sv */
// Self-checking bench for the converter control and result port
`timescale 1ns/100ps
`default_nettype none
module acp_top_bench;
  logic        clk_sys = 0, resetn = 0, reset_pin = 0, pd = 0, cnv_n = 1;
  logic        sp = 0, src = 0, inv = 0, fmt = 0, chain = 0, err_seen = 0;
  logic        lp = 0, ck_prev = 0, sd_hold = 0, int_bad = 0;
  logic [15:0] last = 16'h0000;
  logic [17:0] int_bits = 18'h00000;
  logic [31:0] rnd = 32'h00000000;
  logic [15:0] code = 16'h0000;
  logic [17:0] got;
  wire  [15:0] data_o, data_oe;
  wire         busy, sample_hold, power_save, sclk_i, cs_n, rd_n;
  wire         sdo_pin = data_oe[8] ? data_o[8] : 1'bz;
  integer      err_total = 0, cmp_count = 0, seed = 32'hc43b, cyc = 0, int_cnt = 0;
  acp_top acp_top_i (.clk_sys(clk_sys), .resetn(resetn), .reset_pin(reset_pin),
    .power_down_input(pd), .convert_strobe_n(cnv_n), .low_power_select(lp),
    .fast_mode_select(1'b0), .serial_parallel_select(sp), .clock_source_select(src),
    .clock_invert_select(inv), .marker_polarity_select(rnd[2]),
    .output_format_select(fmt), .readmode_or_chain_input(chain),
    .clock_divide_select(rnd[1:0]), .cs_n(cs_n), .rd_n(rd_n), .sclk_i(sclk_i),
    .adc_code(code), .data_o(data_o), .data_oe(data_oe), .busy(busy),
    .sample_hold(sample_hold), .power_save(power_save));
  acp_host acp_host_i (.sclk_i(sclk_i), .cs_n(cs_n), .rd_n(rd_n), .sdo(sdo_pin));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (sp && src && data_o[11] === 1'b1) err_seen <= 1'b1;
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results;
    end
  end
  // Internal clock looked at mid-cycle; data must hold across both edges
  always @(negedge clk_sys) begin
    ck_prev <= data_o[9] ^ inv;
    if (sp && !src && (data_o[9] ^ inv) && !ck_prev) begin
      int_bits <= {int_bits[16:0], data_o[8]};
      int_cnt  <= int_cnt + 1;
      sd_hold  <= data_o[8];
      if (data_o[10] !== ~rnd[2]) int_bad <= 1'b1;
    end
    if (sp && !src && !(data_o[9] ^ inv) && ck_prev && data_o[8] !== sd_hold)
      int_bad <= 1'b1;
  end
  task automatic chk(input logic [17:0] seen, input logic [17:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic results;
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 40 && busy !== v; k++) @(negedge clk_sys);
  endtask
  task automatic start;
    @(negedge clk_sys) cnv_n = 1'b0;
    wait_busy(1'b1);
    chk(busy, 1'b1);
  endtask
  task automatic conv;
    start;
    cnv_n = 1'b1;
    wait_busy(1'b0);
    chk(busy, 1'b0);
    repeat (12) @(negedge clk_sys);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rnd = $random(seed);
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    acp_host_i.sel(1'b0);
    for (int f = 0; f < 2; f++) begin
      fmt = f[0];
      rnd = $random(seed);
      code = rnd[15:0];
      conv;
      chk(data_o, fmt ? code : code ^ 16'h8000);
      chk(data_oe, 16'hFFFF);
    end
    acp_host_i.sel(1'b1);
    repeat (6) @(negedge clk_sys);
    chk(data_oe, 16'h0000);
    sp = 1'b1;
    src = 1'b1;
    for (int f = 0; f < 2; f++) begin
      inv = f[0];
      rnd = $random(seed);
      code = rnd[15:0];
      chain = rnd[16];
      conv;
      acp_host_i.frame(18, inv, got);
      chk(got, {code, chain, chain});
    end
    // Short read must be flagged only when cut by the next result
    err_seen = 1'b0;
    conv;
    chk(err_seen, 1'b0);
    acp_host_i.frame(5, inv, got);
    err_seen = 1'b0;
    conv;
    chk(err_seen, 1'b1);
    // Internal clock: read after, then during, a conversion
    src = 1'b0;
    int_bad = 1'b0;
    for (int f = 0; f < 2; f++) begin
      chain = f[0];
      last = code;
      rnd = $random(seed);
      code = rnd[15:0];
      int_cnt = 0;
      conv;
      for (int k = 0; k < 1500 && int_cnt < 16; k++) @(negedge clk_sys);
      repeat (80) @(negedge clk_sys);
      chk(int_cnt, 16);
      chk(int_bits[15:0], f ? last : code);
    end
    chk(int_bad, 1'b0);
    // Low-power mode: strobe held low restarts after acquisition
    lp = 1'b1;
    start;
    wait_busy(1'b0);
    repeat (10) @(negedge clk_sys);
    chk(busy, 1'b1);
    cnv_n = 1'b1;
    lp = 1'b0;
    wait_busy(1'b0);
    repeat (12) @(negedge clk_sys);
    start;
    pd = 1'b1;
    cnv_n = 1'b1;
    wait_busy(1'b0);
    repeat (12) @(negedge clk_sys);
    chk(power_save, 1'b1);
    cnv_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk(busy, 1'b0);
    cnv_n = 1'b1;
    pd = 1'b0;
    repeat (12) @(negedge clk_sys);
    start;
    reset_pin = 1'b1;
    cnv_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(busy, 1'b0);
    repeat (4) @(negedge clk_sys);
    conv;
    results;
  end
endmodule // acp_top_bench
`default_nettype wire
